// ---- inc/adcct_pkg.sv ----
// Purpose: Shared constants and types for the converter control block
// Assumes: 8-bit register port, 5-bit module offsets, 8 analog channels
// Notes:   Offsets are byte offsets within the converter module

package adcct_pkg;

	// Bus geometry
	localparam int ADCCT_AW = 5;
	localparam int ADCCT_DW = 8;
	localparam int ADCCT_NCH = 8;
	localparam int ADCCT_CHW = 3;
	localparam int ADCCT_TRIG_CH = 7;
	localparam int ADCCT_SYNC_LEN = 3;

	// Register offsets
	localparam logic [ADCCT_AW-1:0] ADCCT_OFS_RSV_A = 5'h00;
	localparam logic [ADCCT_AW-1:0] ADCCT_OFS_RSV_B = 5'h01;
	localparam logic [ADCCT_AW-1:0] ADCCT_OFS_CTRL  = 5'h02;

	// Control field positions
	localparam int ADCCT_BIT_PWR  = 7;
	localparam int ADCCT_BIT_FFC  = 6;
	localparam int ADCCT_BIT_WPD  = 5;
	localparam int ADCCT_BIT_TLS  = 4;
	localparam int ADCCT_BIT_TPOL = 3;
	localparam int ADCCT_BIT_TEN  = 2;
	localparam int ADCCT_BIT_IEN  = 1;
	localparam int ADCCT_BIT_IFLG = 0;

	// Values after reset
	localparam logic [ADCCT_DW-1:0] ADCCT_CTRL_RST = 8'h00;
	localparam logic [ADCCT_DW-1:0] ADCCT_RSV_RST  = 8'h00;
	localparam logic [ADCCT_DW-1:0] ADCCT_RD_ZERO  = 8'h00;
	localparam logic [ADCCT_NCH-1:0] ADCCT_CH_RST  = 8'h00;
	localparam logic [ADCCT_SYNC_LEN-1:0] ADCCT_SYNC_RST = 3'h0;

	// Trigger sensitivity, {level select, polarity}
	typedef enum logic [1:0] {
		ADCCT_TRIG_FALL = 2'b00,
		ADCCT_TRIG_RISE = 2'b01,
		ADCCT_TRIG_LOW  = 2'b10,
		ADCCT_TRIG_HIGH = 2'b11
	} adcct_trig_mode_t;

	// Wait-mode power state
	typedef enum logic {
		ADCCT_WS_RUN  = 1'b0,
		ADCCT_WS_HALT = 1'b1
	} adcct_wstate_t;

	// Control register layout, bit 7 first
	typedef struct packed {
		logic pwr;
		logic ffc;
		logic wpd;
		logic tls;
		logic tpol;
		logic ten;
		logic ien;
		logic iflg;
	} adcct_ctrl_t;

	// Register port request
	typedef struct packed {
		logic                wr;
		logic                rd;
		logic [ADCCT_AW-1:0] addr;
		logic [ADCCT_DW-1:0] wdata;
	} adcct_bus_req_t;

	// Result register access from the result file
	typedef struct packed {
		logic                 access;
		logic [ADCCT_CHW-1:0] idx;
	} adcct_res_acc_t;

	// Whole state of the control block
	typedef struct packed {
		adcct_ctrl_t                ctrl;
		logic [ADCCT_DW-1:0]        test_a;
		logic [ADCCT_DW-1:0]        test_b;
		logic [ADCCT_DW-1:0]        rdata;
		logic                       abort;
		logic [ADCCT_NCH-1:0]       ccf;
		logic [ADCCT_NCH-1:0]       armed;
		logic [ADCCT_SYNC_LEN-1:0]  sync;
		logic                       trig_lvl;
		logic                       trig_fire;
		adcct_wstate_t              wstate;
		logic                       resume;
		logic                       discard;
		logic                       irq;
	} adcct_state_t;

endpackage

// ---- hw/adcct_ctrl.sv ----
// Purpose: Control register, trigger and flag-clear logic of the converter
// Assumes: Single 40 MHz clock; core and result file on the same clock
// Notes:   Analog core, sequencing and result storage sit outside
//
// Contract
// - Offsets 0x00 and 0x01 read zero and ignore writes in normal modes.
// - Any control register write aborts a running sequence, never starts one.
// - Bit 7 set powers the converter; clear powers it down.
// - Fast-clear off: flag clears on status read followed by result read.
// - Fast-clear on: any result access clears that result's flag.
// - Bit 5 set halts and powers down in wait mode; clear keeps running.
// - Leaving wait by interrupt resumes the halted conversion; discard its result.
// - Bits 4:3 select falling, rising, low level or high level trigger.
// - Bit 2 set makes channel 7 input the external trigger.
// - Bit 1 set requests an interrupt whenever sequence complete is set.
// - Bit 0 mirrors sequence complete while the interrupt enable is set.
// - Bit 0 reads zero with interrupt enable clear; writes to it ignored.
// - Special modes let reserved-location writes alter converter behaviour.
//
// Added by the designer: the strobed register port.

`timescale 1ns/10ps

module adcct_ctrl
	import adcct_pkg::*;
(
	// Clock and reset
	input  wire logic                  i_clk,
	input  wire logic                  i_rst_n,
	// Register port
	input  wire adcct_bus_req_t        i_bus,
	output logic [ADCCT_DW-1:0]        o_rdata,
	// System modes
	input  wire logic                  i_special_mode,
	input  wire logic                  i_wait_mode,
	input  wire logic                  i_wake_irq,
	// Converter core and result file
	input  wire logic                  i_seq_complete,
	input  wire logic [ADCCT_NCH-1:0]  i_ccf_set,
	input  wire logic                  i_status_read,
	input  wire adcct_res_acc_t        i_res,
	// Trigger pin, shared with channel 7
	input  wire logic                  i_trig_pin,
	// Control towards the core
	output adcct_ctrl_t                o_ctrl,
	output logic [ADCCT_DW-1:0]        o_test_a,
	output logic [ADCCT_DW-1:0]        o_test_b,
	output logic                       o_power_on,
	output logic                       o_halt,
	output logic                       o_seq_abort,
	output logic                       o_resume,
	output logic                       o_discard,
	output logic                       o_trig_fire,
	output logic                       o_trig_ch_void,
	// Flags and interrupt
	output logic [ADCCT_NCH-1:0]       o_ccf,
	output logic                       o_irq
);

	adcct_state_t                s_q;
	adcct_state_t                s_d;
	logic [ADCCT_NCH-1:0]        res_hit;
	logic [ADCCT_NCH-1:0]        ccf_clr;
	logic                        flag_view;
	logic                        sync_agree;
	logic                        lvl_next;
	logic                        edge_rise;
	logic                        edge_fall;
	logic                        trig_hit;
	logic                        running;
	adcct_trig_mode_t            trig_mode;

	generate
		if (ADCCT_TRIG_CH >= ADCCT_NCH) begin : g_chk_trig
			$error("Trigger channel outside channel range");
		end
		if ((1 << ADCCT_CHW) < ADCCT_NCH) begin : g_chk_idx
			$error("Result index too narrow for channel count");
		end
		if (ADCCT_SYNC_LEN != 3) begin : g_chk_sync
			$error("Trigger filter needs exactly three stages");
		end
	endgenerate

	// Per-channel flag clear decision
	generate
		for (genvar c = 0; c < ADCCT_NCH; c++) begin : g_ch
			assign res_hit[c] = i_res.access && (i_res.idx == ADCCT_CHW'(c));
			// Fast mode clears on any access, else needs a prior status read
			assign ccf_clr[c] = res_hit[c] &&
				(s_q.ctrl.ffc || s_q.armed[c]);
		end
	endgenerate

	// Bit 0 shows sequence complete only under the enable
	assign flag_view = s_q.ctrl.ien && i_seq_complete;

	// Filtered trigger level moves only when stages two and three agree
	assign sync_agree = (s_q.sync[1] == s_q.sync[2]);
	assign lvl_next   = sync_agree ? s_q.sync[2] : s_q.trig_lvl;
	assign edge_rise  = lvl_next && !s_q.trig_lvl;
	assign edge_fall  = !lvl_next && s_q.trig_lvl;

	assign running   = s_q.ctrl.pwr && (s_q.wstate == ADCCT_WS_RUN);
	assign trig_mode = adcct_trig_mode_t'({s_q.ctrl.tls, s_q.ctrl.tpol});

	always_comb begin
		trig_hit = 1'b0;
		case (trig_mode)
			ADCCT_TRIG_FALL: begin
				trig_hit = edge_fall;
			end
			ADCCT_TRIG_RISE: begin
				trig_hit = edge_rise;
			end
			ADCCT_TRIG_LOW: begin
				trig_hit = !lvl_next;
			end
			ADCCT_TRIG_HIGH: begin
				trig_hit = lvl_next;
			end
			default: begin
				trig_hit = 1'b0;
			end
		endcase
	end

	always_comb begin
		s_d = s_q;
		s_d.abort     = 1'b0;
		s_d.resume    = 1'b0;
		s_d.rdata     = ADCCT_RD_ZERO;

		// Register writes
		if (i_bus.wr) begin
			if (i_bus.addr == ADCCT_OFS_CTRL) begin
				s_d.ctrl      = adcct_ctrl_t'(i_bus.wdata);
				// Flag bit is a view only
				s_d.ctrl.iflg = 1'b0;
				// Abort pulse only; nothing here starts a sequence
				s_d.abort     = 1'b1;
			end else if (i_bus.addr == ADCCT_OFS_RSV_A) begin
				if (i_special_mode) begin
					s_d.test_a = i_bus.wdata;
				end
			end else if (i_bus.addr == ADCCT_OFS_RSV_B) begin
				if (i_special_mode) begin
					s_d.test_b = i_bus.wdata;
				end
			end
		end

		// Register reads, data in the following cycle
		if (i_bus.rd) begin
			if (i_bus.addr == ADCCT_OFS_CTRL) begin
				s_d.rdata = {s_q.ctrl[ADCCT_DW-1:1], flag_view};
			end else if (i_bus.addr == ADCCT_OFS_RSV_A) begin
				s_d.rdata = i_special_mode ? s_q.test_a : ADCCT_RD_ZERO;
			end else if (i_bus.addr == ADCCT_OFS_RSV_B) begin
				s_d.rdata = i_special_mode ? s_q.test_b : ADCCT_RD_ZERO;
			end else begin
				s_d.rdata = ADCCT_RD_ZERO;
			end
		end

		// Normal clear: status read arms set flags, result read disarms
		s_d.armed = (s_q.armed | ({ADCCT_NCH{i_status_read}} & s_q.ccf))
			& ~res_hit;
		// A new completion beats a clear in the same cycle
		s_d.ccf   = (s_q.ccf & ~ccf_clr) | i_ccf_set;
		s_d.armed = s_d.armed & ~i_ccf_set;

		// Three-stage pin filter
		s_d.sync     = {s_q.sync[1:0], i_trig_pin};
		s_d.trig_lvl = lvl_next;
		s_d.trig_fire = s_q.ctrl.ten && running && trig_hit;

		// Wait-mode power control
		case (s_q.wstate)
			ADCCT_WS_RUN: begin
				if (i_wait_mode && s_q.ctrl.wpd) begin
					s_d.wstate = ADCCT_WS_HALT;
				end
			end
			ADCCT_WS_HALT: begin
				if (!i_wait_mode) begin
					s_d.wstate = ADCCT_WS_RUN;
					if (i_wake_irq) begin
						s_d.resume  = 1'b1;
						s_d.discard = 1'b1;
					end
				end else if (!s_q.ctrl.wpd) begin
					s_d.wstate = ADCCT_WS_RUN;
				end
			end
			default: begin
				s_d.wstate = ADCCT_WS_RUN;
			end
		endcase

		// Discard marker lasts until the resumed conversion lands or a sequence abort
		if (s_q.discard && ((|i_ccf_set) || s_q.abort)) begin
			s_d.discard = 1'b0;
		end

		// Registered interrupt request
		s_d.irq = flag_view;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_q.ctrl      <= adcct_ctrl_t'(ADCCT_CTRL_RST);
			s_q.test_a    <= ADCCT_RSV_RST;
			s_q.test_b    <= ADCCT_RSV_RST;
			s_q.rdata     <= ADCCT_RD_ZERO;
			s_q.abort     <= 1'b0;
			s_q.ccf       <= ADCCT_CH_RST;
			s_q.armed     <= ADCCT_CH_RST;
			s_q.sync      <= ADCCT_SYNC_RST;
			s_q.trig_lvl  <= 1'b0;
			s_q.trig_fire <= 1'b0;
			s_q.wstate    <= ADCCT_WS_RUN;
			s_q.resume    <= 1'b0;
			s_q.discard   <= 1'b0;
			s_q.irq       <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs
	assign o_rdata        = s_q.rdata;
	assign o_ctrl         = s_q.ctrl;
	assign o_test_a       = s_q.test_a;
	assign o_test_b       = s_q.test_b;
	assign o_power_on     = running;
	assign o_halt         = (s_q.wstate == ADCCT_WS_HALT);
	assign o_seq_abort    = s_q.abort;
	assign o_resume       = s_q.resume;
	assign o_discard      = s_q.discard;
	assign o_trig_fire    = s_q.trig_fire;
	// Channel 7 results are void while it serves as trigger
	assign o_trig_ch_void = s_q.ctrl.ten;
	assign o_ccf          = s_q.ccf;
	assign o_irq          = s_q.irq;

endmodule

// ---- dv/adcct_ctrl_props.sv ----
// Purpose: Concurrent checks on the converter control block ports
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Attached to every adcct_ctrl instance by bind
`timescale 1ns/10ps
module adcct_ctrl_props
	import adcct_pkg::*;
(
	// Clock and reset
	input wire logic                 i_clk,
	input wire logic                 i_rst_n,
	// Inputs watched
	input wire adcct_bus_req_t       i_bus,
	input wire logic                 i_special_mode,
	input wire logic                 i_wait_mode,
	input wire logic                 i_seq_complete,
	input wire logic [ADCCT_NCH-1:0] i_ccf_set,
	input wire adcct_res_acc_t       i_res,
	// Outputs watched
	input wire logic [ADCCT_DW-1:0]  o_rdata,
	input wire adcct_ctrl_t          o_ctrl,
	input wire logic                 o_power_on,
	input wire logic                 o_halt,
	input wire logic                 o_seq_abort,
	input wire logic                 o_trig_fire,
	input wire logic [ADCCT_NCH-1:0] o_ccf,
	input wire logic                 o_irq
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	logic wr_ctl;
	assign wr_ctl = i_bus.wr && (i_bus.addr == ADCCT_OFS_CTRL);
	AST_RSV_ZERO: assert property (i_bus.rd && i_bus.addr < 5'h02 && !i_special_mode
		|=> o_rdata == 8'h00) else $error("reserved read not zero");
	AST_ABORT: assert property (wr_ctl |=> o_seq_abort) else $error("no abort");
	AST_NO_ABORT: assert property (o_seq_abort |-> $past(wr_ctl)) else $error("stray abort");
	AST_CTRL_WR: assert property (wr_ctl |=> o_ctrl == {$past(i_bus.wdata[7:1]), 1'b0})
		else $error("control write wrong");
	AST_PWR: assert property (o_power_on |-> o_ctrl.pwr && !o_halt) else $error("power wrong");
	AST_HALT: assert property (i_wait_mode && o_ctrl.wpd |=> o_halt) else $error("no halt");
	AST_NO_HALT: assert property (!o_ctrl.wpd && !$past(o_ctrl.wpd) |-> !o_halt)
		else $error("halt without wpd");
	AST_IRQ_ON: assert property (o_ctrl.ien && i_seq_complete |=> o_irq) else $error("no irq");
	AST_IRQ_OFF: assert property (!o_ctrl.ien && !$past(o_ctrl.ien) |-> !o_irq)
		else $error("irq while disabled");
	AST_IFLG: assert property (o_ctrl.iflg == 1'b0) else $error("flag bit set");
	AST_FAST: assert property (o_ctrl.ffc && i_res.access && !i_ccf_set[i_res.idx]
		|=> !o_ccf[$past(i_res.idx)]) else $error("fast clear missed");
	AST_TRIG_OFF: assert property (!o_ctrl.ten && !$past(o_ctrl.ten) |-> !o_trig_fire)
		else $error("trigger while disabled");
	AST_RD_IDLE: assert property (!i_bus.rd |=> o_rdata == 8'h00)
		else $error("read data outside read cycle");
	cover property (o_halt);
	cover property (o_trig_fire);
	cover property (o_irq);
endmodule

bind adcct_ctrl adcct_ctrl_props u_props (.i_clk, .i_rst_n, .i_bus, .i_special_mode,
	.i_wait_mode, .i_seq_complete, .i_ccf_set, .i_res, .o_rdata, .o_ctrl, .o_power_on,
	.o_halt, .o_seq_abort, .o_trig_fire, .o_ccf, .o_irq);

// ---- dv/adcct_ctrl_tb.sv ----
// Purpose: Self-checking bench for the converter control block
// Assumes: 40 MHz clock, bench drives every port
// Notes:   Trigger modes run from a table, the rest by hand
`timescale 1ns/10ps
module adcct_ctrl_tb
	import adcct_pkg::*;
;
	typedef struct packed {logic [7:0] ctl; logic p0; logic p1; logic [3:0] lo; logic [3:0] hi;} adcct_row_t;
	localparam adcct_row_t ROWS [6] = '{'{8'h84, 1, 0, 1, 1}, '{8'h8c, 0, 1, 1, 1},
		'{8'h94, 1, 0, 5, 10}, '{8'h9c, 0, 1, 5, 10}, '{8'h88, 0, 1, 0, 0}, '{8'h8c, 1, 0, 0, 0}};
	logic i_clk = 0, i_rst_n = 0, i_special_mode = 0, i_wait_mode = 0, i_wake_irq = 0;
	logic i_seq_complete = 0, i_status_read = 0, i_trig_pin = 0;
	logic [7:0] i_ccf_set = '0, o_rdata, o_test_a, o_test_b, o_ccf;
	adcct_bus_req_t i_bus = '0;
	adcct_res_acc_t i_res = '0;
	adcct_ctrl_t o_ctrl;
	logic o_power_on, o_halt, o_seq_abort, o_resume, o_discard, o_trig_fire, o_trig_ch_void, o_irq;
	int errors = 0, checks = 0, cnt;
	adcct_ctrl uut (.i_clk, .i_rst_n, .i_bus, .o_rdata, .i_special_mode, .i_wait_mode,
		.i_wake_irq, .i_seq_complete, .i_ccf_set, .i_status_read, .i_res, .i_trig_pin,
		.o_ctrl, .o_test_a, .o_test_b, .o_power_on, .o_halt, .o_seq_abort, .o_resume,
		.o_discard, .o_trig_fire, .o_trig_ch_void, .o_ccf, .o_irq);
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(logic [4:0] a, logic [7:0] d);
		@(posedge i_clk) i_bus <= '{1'b1, 1'b0, a, d};
		@(posedge i_clk) i_bus.wr <= 1'b0;
		#1;
	endtask
	task automatic rd(logic [4:0] a, logic [7:0] e);
		@(posedge i_clk) i_bus <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge i_clk) i_bus.rd <= 1'b0;
		#1 chk("rdata", e, o_rdata);
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic give_verdict();
		$display("errors=%0d checks=%0d", errors, checks);
		if (errors == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		forever #12.5 i_clk = ~i_clk;
	end
	initial begin
		#100000 errors++;
		give_verdict();
	end
	initial begin
		repeat (12) @(posedge i_clk);
		i_rst_n <= 1'b1;
		#1 chk("ctrl_rst", ADCCT_CTRL_RST, o_ctrl);
		rd(ADCCT_OFS_CTRL, 8'h00);
		foreach (ROWS[i]) begin
			@(posedge i_clk) i_trig_pin <= ROWS[i].p0;
			wr(ADCCT_OFS_CTRL, ROWS[i].ctl);
			chk("abort", 8'h01, {7'h00, o_seq_abort});
			chk("trig_void", {7'h00, ROWS[i].ctl[2]}, {7'h00, o_trig_ch_void});
			rd(ADCCT_OFS_CTRL, ROWS[i].ctl);
			// Recovery time after power-on
			repeat (6) @(posedge i_clk);
			i_trig_pin <= ROWS[i].p1;
			cnt = 0;
			repeat (10) begin
				tick(1);
				cnt += o_trig_fire;
			end
			chk("fire", 8'h01, {7'h00, cnt >= ROWS[i].lo && cnt <= ROWS[i].hi});
		end
		wr(ADCCT_OFS_RSV_A, 8'h5a);
		chk("test_a_normal", 8'h00, o_test_a);
		rd(ADCCT_OFS_RSV_A, 8'h00);
		rd(ADCCT_OFS_RSV_B, 8'h00);
		rd(5'h1f, 8'h00);
		@(posedge i_clk) i_special_mode <= 1'b1;
		wr(ADCCT_OFS_RSV_A, 8'ha5);
		chk("test_a", 8'ha5, o_test_a);
		wr(ADCCT_OFS_RSV_B, 8'h3c);
		chk("test_b", 8'h3c, o_test_b);
		rd(ADCCT_OFS_RSV_B, 8'h3c);
		@(posedge i_clk) i_special_mode <= 1'b0;
		i_seq_complete <= 1'b1;
		wr(ADCCT_OFS_CTRL, 8'h83);
		rd(ADCCT_OFS_CTRL, 8'h83);
		chk("irq", 8'h01, {7'h00, o_irq});
		wr(ADCCT_OFS_CTRL, 8'h81);
		rd(ADCCT_OFS_CTRL, 8'h80);
		chk("irq_off", 8'h00, {7'h00, o_irq});
		// Result access without status read keeps the flag
		@(posedge i_clk) i_ccf_set <= 8'h08;
		@(posedge i_clk) i_ccf_set <= 8'h00;
		i_res <= '{1'b1, 3'd3};
		@(posedge i_clk) i_res <= '0;
		tick(1);
		chk("ccf_hold", 8'h08, o_ccf);
		@(posedge i_clk) i_status_read <= 1'b1;
		@(posedge i_clk) i_status_read <= 1'b0;
		i_res <= '{1'b1, 3'd3};
		@(posedge i_clk) i_res <= '0;
		tick(1);
		chk("ccf_clr", 8'h00, o_ccf);
		wr(ADCCT_OFS_CTRL, 8'hc0);
		@(posedge i_clk) i_ccf_set <= 8'h20;
		@(posedge i_clk) i_ccf_set <= 8'h00;
		i_res <= '{1'b1, 3'd5};
		@(posedge i_clk) i_res <= '0;
		tick(1);
		chk("ccf_fast", 8'h00, o_ccf);
		wr(ADCCT_OFS_CTRL, 8'ha0);
		@(posedge i_clk) i_wait_mode <= 1'b1;
		tick(3);
		chk("halt", 8'h02, {6'h00, o_halt, o_power_on});
		@(posedge i_clk) i_wait_mode <= 1'b0;
		i_wake_irq <= 1'b1;
		@(posedge i_clk) i_wake_irq <= 1'b0;
		#1 chk("resume", 8'h03, {6'h00, o_resume, o_discard});
		wr(ADCCT_OFS_CTRL, 8'h80);
		@(posedge i_clk) i_wait_mode <= 1'b1;
		tick(3);
		chk("run_in_wait", 8'h01, {6'h00, o_halt, o_power_on});
		@(posedge i_clk) i_wait_mode <= 1'b0;
		// Mid-run reset with a flag set and the converter powered
		@(posedge i_clk) i_ccf_set <= 8'h01;
		@(posedge i_clk) i_ccf_set <= 8'h00;
		i_rst_n <= 1'b0;
		tick(2);
		chk("ccf_rst", ADCCT_CH_RST, o_ccf);
		chk("ctrl_rst2", ADCCT_CTRL_RST, o_ctrl);
		@(posedge i_clk) i_rst_n <= 1'b1;
		#1 chk("pwr_rst", 8'h00, {7'h00, o_power_on});
		rd(ADCCT_OFS_CTRL, 8'h00);
		give_verdict();
	end
endmodule
